// ===== hw/afps_pin_select.sv
// afps_pin_select: alternate function select for four port C and two port D pads
// assumes Avalon-MM master with byte addresses, timer/SPI/CAN/memory peripherals on ref_clk
//
// Implementation choice: the Avalon-MM register port.
`timescale 1ns/1ps
`default_nettype none

module afps_pin_select (
   input  wire logic                                  ref_clk,
   input  wire logic                                  reset_n,
   // avalon-mm slave
   input  wire logic [afps_pkg::ADDR_W-1:0]           avs_address,
   input  wire logic                                  avs_read,
   input  wire logic                                  avs_write,
   input  wire logic [afps_pkg::DATA_W-1:0]           avs_writedata,
   input  wire logic [3:0]                            avs_byteenable,
   output logic      [afps_pkg::DATA_W-1:0]           avs_readdata,
   output logic                                       avs_waitrequest,
   // port C pads
   input  wire logic [afps_pkg::PORTC_PINS-1:0]       portc_pad_in,
   output afps_pkg::afps_pad_drive_type [afps_pkg::PORTC_PINS-1:0] portc_pad_drive,
   // port D pads
   input  wire logic [afps_pkg::PORTD_PINS-1:0]       portd_pad_in,
   output afps_pkg::afps_pad_drive_type [afps_pkg::PORTD_PINS-1:0] portd_pad_drive,
   // gpio data path
   input  wire logic [afps_pkg::PORTC_PINS-1:0]       portc_gpio_out,
   output logic      [afps_pkg::PORTC_PINS-1:0]       portc_gpio_in,
   input  wire logic [afps_pkg::PORTD_PINS-1:0]       portd_gpio_out,
   output logic      [afps_pkg::PORTD_PINS-1:0]       portd_gpio_in,
   // decoder and timer, bit i is channel i
   input  wire logic [afps_pkg::PORTC_PINS-1:0]       timer_out,
   input  wire logic [afps_pkg::PORTC_PINS-1:0]       timer_output_enable,
   output logic      [afps_pkg::PORTC_PINS-1:0]       timer_in,
   output logic      [afps_pkg::PORTC_PINS-1:0]       decoder_in,
   // spi2: bit 0 clock, 1 mosi, 2 miso, 3 slave select
   input  wire logic [afps_pkg::PORTC_PINS-1:0]       spi2_out,
   input  wire logic [afps_pkg::PORTC_PINS-1:0]       spi2_drive,
   output logic      [afps_pkg::PORTC_PINS-1:0]       spi2_in,
   // memory interface and second can
   input  wire logic                                  mem_chip_select_2,
   input  wire logic                                  mem_chip_select_3,
   input  wire logic                                  second_can_transmit,
   output logic                                       second_can_receive
);

   localparam int unsigned PC = afps_pkg::PORTC_PINS;
   localparam int unsigned PD = afps_pkg::PORTD_PINS;

   logic [afps_pkg::SEL_W-1:0] sel_r;
   logic [PC-1:0]              pc_per_r;
   logic [PC-1:0]              pc_dir_r;
   logic [PD-1:0]              pd_per_r;
   logic [PD-1:0]              pd_dir_r;
   logic                       wait_r;
   logic [afps_pkg::DATA_W-1:0] rdata_r;
   logic [afps_pkg::DATA_W-1:0] rdata_nxt;
   logic [afps_pkg::IDX_W-1:0]  idx;
   logic                        req;
   logic                        wr_ack;
   logic [PC-1:0]               pc_sel;
   logic [PC-1:0]               pc_out;
   logic [PC-1:0]               pc_drv;
   logic [PD-1:0]               pd_out;
   logic [PD-1:0]               pd_drv;
   logic [PC-1:0]               pc_oe_n;
   logic [PD-1:0]               pd_oe_n;

   // merge one 16-bit field under byte enables
   function automatic logic [15:0] be_merge(input logic [15:0] old_v,
                                            input logic [15:0] new_v,
                                            input logic [1:0]  be);
      logic [15:0] res;
      res = old_v;
      if (be[0]) begin
         res[7:0] = new_v[7:0];
      end
      if (be[1]) begin
         res[15:8] = new_v[15:8];
      end
      return res;
   endfunction : be_merge

   assign idx    = avs_address[afps_pkg::ADDR_W-1:2];
   assign req    = avs_read | avs_write;
   assign wr_ack = avs_write & ~wait_r;
   assign pc_sel = sel_r[afps_pkg::SEL_PORTC_LSB +: PC];

   // one wait cycle, then the request is taken
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         wait_r <= 1'b1;
      end else begin
         wait_r <= ~(req & wait_r);
      end
   end

   // read mux, unmapped reads return zero
   always_comb begin
      rdata_nxt = '0;
      case (idx)
         afps_pkg::SEL_IDX: begin
            rdata_nxt[afps_pkg::SEL_W-1:0] = sel_r;
         end
         afps_pkg::CFG_IDX: begin
            rdata_nxt[afps_pkg::CFG_PC_PER_LSB +: PC] = pc_per_r;
            rdata_nxt[afps_pkg::CFG_PC_DIR_LSB +: PC] = pc_dir_r;
            rdata_nxt[afps_pkg::CFG_PD_PER_LSB +: PD] = pd_per_r;
            rdata_nxt[afps_pkg::CFG_PD_DIR_LSB +: PD] = pd_dir_r;
         end
         afps_pkg::STAT_IDX: begin
            rdata_nxt[afps_pkg::STAT_PC_LSB +: PC] = ~pc_oe_n;
            rdata_nxt[afps_pkg::STAT_PD_LSB +: PD] = ~pd_oe_n;
         end
         default: begin
            rdata_nxt = '0;
         end
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         rdata_r <= '0;
      end else if (avs_read && wait_r) begin
         rdata_r <= rdata_nxt;
      end
   end

   // select register, upper bits not stored
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         sel_r <= afps_pkg::SEL_RESET;
      end else if (wr_ack && idx == afps_pkg::SEL_IDX) begin
         sel_r <= afps_pkg::SEL_W'(be_merge(16'(sel_r), avs_writedata[15:0],
                                            avs_byteenable[1:0]));
      end
   end

   // per-pad enable and direction bits
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         pc_per_r <= afps_pkg::PC_PER_RESET;
         pc_dir_r <= afps_pkg::PC_DIR_RESET;
         pd_per_r <= afps_pkg::PD_PER_RESET;
         pd_dir_r <= afps_pkg::PD_DIR_RESET;
      end else if (wr_ack && idx == afps_pkg::CFG_IDX) begin
         pc_per_r <= avs_byteenable[0] ?
                     avs_writedata[afps_pkg::CFG_PC_PER_LSB +: PC] : pc_per_r;
         pc_dir_r <= avs_byteenable[0] ?
                     avs_writedata[afps_pkg::CFG_PC_DIR_LSB +: PC] : pc_dir_r;
         pd_per_r <= avs_byteenable[1] ?
                     avs_writedata[afps_pkg::CFG_PD_PER_LSB +: PD] : pd_per_r;
         pd_dir_r <= avs_byteenable[1] ?
                     avs_writedata[afps_pkg::CFG_PD_DIR_LSB +: PD] : pd_dir_r;
      end
   end

   // port C peripheral routing
   always_comb begin
      for (int i = 0; i < PC; i++) begin
         if (pc_sel[i]) begin
            pc_out[i] = spi2_out[i];
            pc_drv[i] = spi2_drive[i];
         end else begin
            pc_out[i] = timer_out[i];
            pc_drv[i] = timer_output_enable[i];
         end
      end
   end

   // port D peripheral routing
   always_comb begin
      if (sel_r[afps_pkg::SEL_PD0_BIT]) begin
         pd_out[0] = second_can_transmit;
      end else begin
         pd_out[0] = mem_chip_select_2;
      end
      pd_drv[0] = 1'b1;
      if (sel_r[afps_pkg::SEL_PD1_BIT]) begin
         pd_out[1] = 1'b0;
         pd_drv[1] = 1'b0;
      end else begin
         pd_out[1] = mem_chip_select_3;
         pd_drv[1] = 1'b1;
      end
   end

   for (genvar g = 0; g < PC; g++) begin : g_portc
      afps_pad_cell u_cell (
         .ref_clk        (ref_clk),
         .reset_n        (reset_n),
         .periph_enable  (pc_per_r[g]),
         .gpio_direction (pc_dir_r[g]),
         .gpio_out       (portc_gpio_out[g]),
         .periph_out     (pc_out[g]),
         .periph_drive   (pc_drv[g]),
         .pad_drive      (portc_pad_drive[g])
      );
      assign pc_oe_n[g] = portc_pad_drive[g].oe_n;
   end

   for (genvar g = 0; g < PD; g++) begin : g_portd
      afps_pad_cell u_cell (
         .ref_clk        (ref_clk),
         .reset_n        (reset_n),
         .periph_enable  (pd_per_r[g]),
         .gpio_direction (pd_dir_r[g]),
         .gpio_out       (portd_gpio_out[g]),
         .periph_out     (pd_out[g]),
         .periph_drive   (pd_drv[g]),
         .pad_drive      (portd_pad_drive[g])
      );
      assign pd_oe_n[g] = portd_pad_drive[g].oe_n;
   end

   // pad inputs to gpio and peripherals
   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         portc_gpio_in <= '0;
         portd_gpio_in <= '0;
         timer_in      <= '0;
         decoder_in    <= '0;
         spi2_in       <= '0;
      end else begin
         portc_gpio_in <= portc_pad_in;
         portd_gpio_in <= portd_pad_in;
         timer_in      <= portc_pad_in & pc_per_r & ~pc_sel;
         decoder_in    <= portc_pad_in & pc_per_r & ~pc_sel;
         spi2_in       <= portc_pad_in & pc_per_r & pc_sel;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         second_can_receive <= afps_pkg::CAN_IDLE;
      end else if (pd_per_r[1] && sel_r[afps_pkg::SEL_PD1_BIT]) begin
         second_can_receive <= portd_pad_in[1];
      end else begin
         second_can_receive <= afps_pkg::CAN_IDLE;
      end
   end

   assign avs_readdata    = rdata_r;
   assign avs_waitrequest = wait_r;

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);

   AST_RSV_ZERO: assert property (
      (avs_read && wait_r && idx == afps_pkg::SEL_IDX)
      |=> (avs_readdata[afps_pkg::DATA_W-1:afps_pkg::SEL_W] == '0))
      else $error("reserved select bits read nonzero");

   AST_SEL_WRITE: assert property (
      (wr_ack && idx == afps_pkg::SEL_IDX && avs_byteenable[0])
      |=> (sel_r == $past(avs_writedata[afps_pkg::SEL_W-1:0])))
      else $error("select write not stored");

   AST_RESET_VALS: assert property (
      $rose(reset_n) |-> (sel_r == '0 && pc_per_r == afps_pkg::PC_PER_RESET
                          && pd_per_r == '0))
      else $error("reset values of select or enables wrong");

   AST_PD1_CS: assert property (
      (pd_per_r[1] && !sel_r[afps_pkg::SEL_PD1_BIT])
      |=> (!portd_pad_drive[1].oe_n && portd_pad_drive[1].out == $past(mem_chip_select_3)))
      else $error("port D pin 1 not driving chip select 3");

   AST_PD0_ROUTE: assert property (
      pd_per_r[0] |=> (!portd_pad_drive[0].oe_n && portd_pad_drive[0].out ==
         ($past(sel_r[afps_pkg::SEL_PD0_BIT]) ? $past(second_can_transmit)
                                              : $past(mem_chip_select_2))))
      else $error("port D pin 0 routing wrong");

   AST_CAN_RX: assert property (
      (pd_per_r[1] && sel_r[afps_pkg::SEL_PD1_BIT])
      |=> (portd_pad_drive[1].oe_n && second_can_receive == $past(portd_pad_in[1])))
      else $error("can receive pad not an input");

   AST_TIMER_DIR: assert property (
      (pc_per_r[2] && !pc_sel[2])
      |=> (portc_pad_drive[2].oe_n == !$past(timer_output_enable[2])))
      else $error("timer output enable not applied");

   AST_SPI_DIR: assert property (
      (pc_per_r[0] && pc_sel[0])
      |=> (portc_pad_drive[0].oe_n == !$past(spi2_drive[0])
           && portc_pad_drive[0].out == $past(spi2_out[0])))
      else $error("spi clock pad not following spi direction");

   AST_DECODER_IN: assert property (
      (pc_per_r[1] && !pc_sel[1]) |=> (decoder_in[1] == $past(portc_pad_in[1])
                                       && spi2_in[1] == 1'b0))
      else $error("decoder input not taken from pad");

   AST_GPIO_C: assert property (
      !pc_per_r[3] |=> (portc_pad_drive[3].oe_n == !$past(pc_dir_r[3])))
      else $error("port C gpio mode ignores direction");

   AST_GPIO_MASK: assert property (
      !pc_per_r[1] |=> (timer_in[1] == 1'b0 && decoder_in[1] == 1'b0
                        && spi2_in[1] == 1'b0))
      else $error("peripheral inputs fed while pad in gpio mode");

   AST_PD1_GPIO: assert property (
      !pd_per_r[1] |=> (portd_pad_drive[1].oe_n == !$past(pd_dir_r[1])))
      else $error("port D gpio mode ignores direction");

   AST_TIMER_IN: assert property (
      (pc_per_r[0] && !pc_sel[0]) |=> (timer_in[0] == $past(portc_pad_in[0])))
      else $error("timer input not taken from pad");

   AST_TIMER_OUT: assert property (
      (pc_per_r[3] && !pc_sel[3]) |=> (portc_pad_drive[3].out == $past(timer_out[3])))
      else $error("timer output not routed to pad");

   AST_SPI_IN: assert property (
      (pc_per_r[2] && pc_sel[2]) |=> (spi2_in[2] == $past(portc_pad_in[2])
                                      && timer_in[2] == 1'b0 && decoder_in[2] == 1'b0))
      else $error("spi miso input not taken from pad");

   AST_CAN_IDLE: assert property (
      !(pd_per_r[1] && sel_r[afps_pkg::SEL_PD1_BIT])
      |=> (second_can_receive == afps_pkg::CAN_IDLE))
      else $error("can receive not idle while unrouted");

   AST_CFG_WRITE: assert property (
      (wr_ack && idx == afps_pkg::CFG_IDX && avs_byteenable[1])
      |=> (pd_per_r == $past(avs_writedata[afps_pkg::CFG_PD_PER_LSB +: PD])))
      else $error("port D enable write not stored");

   AST_SEL_HOLD: assert property (
      !(wr_ack && idx == afps_pkg::SEL_IDX) |=> $stable(sel_r))
      else $error("select register changed without a write");

   AST_WAIT_ONE: assert property (
      (req && wait_r) |=> !avs_waitrequest ##1 avs_waitrequest)
      else $error("waitrequest not one cycle low");

endmodule : afps_pin_select

`default_nettype wire

// ===== hw/afps_pkg.sv
// afps_pkg: constants, register map and carrier types of the alternate function pin select
// assumes a 32-bit Avalon-MM slave port with byte addresses and word-aligned registers
//
// Behaviour
// - select register bits 15..6 read zero, writes to them are dropped
// - bit 5: port D pin 1 chip select 3 / CAN receive; bit 4: chip select 2 / CAN transmit
// - bit 3: port C pin 3 decoder home timer ch3, or SPI2 slave select
// - bit 2: port C pin 2 decoder index timer ch2, or SPI2 MISO
// - bit 1: port C pin 1 decoder phase B timer ch1, or SPI2 MOSI
// - bit 0: port C pin 0 decoder phase A timer ch0, or SPI2 clock
// - all select bits reset to zero: decoder/timer and chip selects by default
// - port C resets in peripheral mode; peripheral enable clear gives GPIO, select ignored
// - port D resets in GPIO mode; direction bit 0 input, 1 output
// - port C decoder/timer mode: timer output enable 0 input, 1 output
// - port C SPI mode: pad direction follows SPI2 direction control
// - decoder signals on port C are always inputs, alongside timer functions
// - memory mode: chip selects always drive; CAN transmit output, receive input
// - each pad has its own enable, direction and select bits

package afps_pkg;

   localparam int unsigned ADDR_W      = 8;
   localparam int unsigned DATA_W      = 32;
   localparam int unsigned IDX_W       = 6;
   localparam int unsigned PORTC_PINS  = 4;
   localparam int unsigned PORTD_PINS  = 2;
   localparam int unsigned SEL_W       = 6;

   // register indices, byte address is four times the index
   localparam logic [IDX_W-1:0] SEL_IDX  = 6'h0b;
   localparam logic [IDX_W-1:0] CFG_IDX  = 6'h10;
   localparam logic [IDX_W-1:0] STAT_IDX = 6'h11;

   // select register fields
   localparam int unsigned SEL_PORTC_LSB = 0;
   localparam int unsigned SEL_PD0_BIT   = 4;
   localparam int unsigned SEL_PD1_BIT   = 5;
   localparam logic [SEL_W-1:0] SEL_RESET = 6'h00;

   // configuration register fields
   localparam int unsigned CFG_PC_PER_LSB = 0;
   localparam int unsigned CFG_PC_DIR_LSB = 4;
   localparam int unsigned CFG_PD_PER_LSB = 8;
   localparam int unsigned CFG_PD_DIR_LSB = 10;
   localparam logic [PORTC_PINS-1:0] PC_PER_RESET = 4'hf;
   localparam logic [PORTC_PINS-1:0] PC_DIR_RESET = 4'h0;
   localparam logic [PORTD_PINS-1:0] PD_PER_RESET = 2'h0;
   localparam logic [PORTD_PINS-1:0] PD_DIR_RESET = 2'h0;

   // status register fields
   localparam int unsigned STAT_PC_LSB = 0;
   localparam int unsigned STAT_PD_LSB = 4;

   // idle level of the CAN receive line when not routed
   localparam logic CAN_IDLE = 1'b1;

   // one pad: value and active-low output enable
   typedef struct packed {
      logic out;
      logic oe_n;
   } afps_pad_drive_type;

   localparam afps_pad_drive_type PAD_RESET = '{out: 1'b0, oe_n: 1'b1};

endpackage : afps_pkg

// ===== hw/afps_pad_cell.sv
// afps_pad_cell: output stage of one shared pad, GPIO or routed peripheral
// assumes pad inputs synchronous to ref_clk; drive is registered
`timescale 1ns/1ps
`default_nettype none

module afps_pad_cell (
   input  wire logic                        ref_clk,
   input  wire logic                        reset_n,
   input  wire logic                        periph_enable,
   input  wire logic                        gpio_direction,
   input  wire logic                        gpio_out,
   input  wire logic                        periph_out,
   input  wire logic                        periph_drive,
   output var  afps_pkg::afps_pad_drive_type pad_drive
);

   afps_pkg::afps_pad_drive_type drive_nxt;

   // gpio when enable clear, routed peripheral otherwise
   always_comb begin
      if (periph_enable) begin
         drive_nxt.out  = periph_out;
         drive_nxt.oe_n = ~periph_drive;
      end else begin
         drive_nxt.out  = gpio_out;
         drive_nxt.oe_n = ~gpio_direction;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (!reset_n) begin
         pad_drive <= afps_pkg::PAD_RESET;
      end else begin
         pad_drive <= drive_nxt;
      end
   end

   AST_GPIO_DIR: assert property (@(posedge ref_clk) disable iff (!reset_n)
      !periph_enable |=> (pad_drive.oe_n == !$past(gpio_direction))
                         && (pad_drive.out == $past(gpio_out)))
      else $error("gpio direction not applied to pad");

endmodule : afps_pad_cell

`default_nettype wire

// ===== sim/afps_pad_world.sv
// afps_pad_world: wire level of the six shared pads as the outside world sees them
// assumes the bench sets the outside level of every pad the block leaves undriven
`timescale 1ns/1ps
`default_nettype none

module afps_pad_world (
   input  wire afps_pkg::afps_pad_drive_type [afps_pkg::PORTC_PINS-1:0] portc_pad_drive,
   input  wire afps_pkg::afps_pad_drive_type [afps_pkg::PORTD_PINS-1:0] portd_pad_drive,
   input  wire logic [afps_pkg::PORTC_PINS-1:0]                         ext_c,
   input  wire logic [afps_pkg::PORTD_PINS-1:0]                         ext_d,
   output logic      [afps_pkg::PORTC_PINS-1:0]                         portc_pad_in,
   output logic      [afps_pkg::PORTD_PINS-1:0]                         portd_pad_in
);
   // a driving pad wins, a released one shows the outside level
   always_comb begin
      for (int i = 0; i < afps_pkg::PORTC_PINS; i++) begin
         portc_pad_in[i] = !portc_pad_drive[i].oe_n ? portc_pad_drive[i].out : ext_c[i];
      end
      for (int j = 0; j < afps_pkg::PORTD_PINS; j++) begin
         portd_pad_in[j] = !portd_pad_drive[j].oe_n ? portd_pad_drive[j].out : ext_d[j];
      end
   end
endmodule : afps_pad_world

`default_nettype wire

// ===== sim/afps_pin_select_bench.sv
// afps_pin_select_bench: self-checking bench of the alternate function pin select
// assumes afps_pkg, afps_pin_select and afps_pad_world compiled before it
`timescale 1ns/1ps
`default_nettype none

module afps_pin_select_bench;
   logic ref_clk, reset_n, avs_read, avs_write, avs_waitrequest;
   logic [7:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata;
   logic [3:0] avs_byteenable, portc_pad_in, portc_gpio_out, portc_gpio_in, ext_c;
   logic [3:0] timer_out, timer_output_enable, timer_in, decoder_in, spi2_out, spi2_drive, spi2_in;
   logic [1:0] portd_pad_in, portd_gpio_out, portd_gpio_in, ext_d;
   logic mem_chip_select_2, mem_chip_select_3, second_can_transmit, second_can_receive;
   afps_pkg::afps_pad_drive_type [3:0] pc_drv;
   afps_pkg::afps_pad_drive_type [1:0] pd_drv;
   logic [5:0] sel_s;
   logic [11:0] cfg_s;
   int err_count, n_checks, cyc_count;

   afps_pin_select dut_u (.ref_clk(ref_clk), .reset_n(reset_n), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .portc_pad_in(portc_pad_in), .portc_pad_drive(pc_drv),
      .portd_pad_in(portd_pad_in), .portd_pad_drive(pd_drv), .portc_gpio_out(portc_gpio_out),
      .portc_gpio_in(portc_gpio_in), .portd_gpio_out(portd_gpio_out),
      .portd_gpio_in(portd_gpio_in), .timer_out(timer_out),
      .timer_output_enable(timer_output_enable), .timer_in(timer_in), .decoder_in(decoder_in),
      .spi2_out(spi2_out), .spi2_drive(spi2_drive), .spi2_in(spi2_in),
      .mem_chip_select_2(mem_chip_select_2), .mem_chip_select_3(mem_chip_select_3),
      .second_can_transmit(second_can_transmit), .second_can_receive(second_can_receive));

   afps_pad_world pads_u (.portc_pad_drive(pc_drv), .portd_pad_drive(pd_drv), .ext_c(ext_c),
      .ext_d(ext_d), .portc_pad_in(portc_pad_in), .portd_pad_in(portd_pad_in));

   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end

   // hang guard
   always @(posedge ref_clk) begin
      cyc_count <= cyc_count + 1;
      if (cyc_count == 20000) begin
         err_count++;
         give_verdict();
      end
   end

   task automatic give_verdict;
      if (err_count == 0 && n_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : give_verdict

   task automatic compare(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : compare

   task automatic bus_wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
      avs_address <= a;
      avs_writedata <= d;
      avs_byteenable <= be;
      avs_write <= 1'b1;
      do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
      avs_write <= 1'b0;
      @(posedge ref_clk);
   endtask : bus_wr

   task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
      avs_address <= a;
      avs_read <= 1'b1;
      do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
      d = avs_readdata;
      avs_read <= 1'b0;
      @(posedge ref_clk);
   endtask : bus_rd

   task automatic wr_sel(input logic [5:0] s);
      bus_wr(8'h2c, {26'h0, s}, 4'h1);
      sel_s = s;
   endtask : wr_sel

   task automatic wr_cfg(input logic [11:0] c);
      bus_wr(8'h40, {20'h0, c}, 4'h3);
      cfg_s = c;
   endtask : wr_cfg

   // expected pad routing from the shadow registers and peripheral inputs
   task automatic check_all;
      logic [3:0] cd, co, cp, ti, si;
      logic [1:0] dd, dout, dp;
      logic [31:0] r;
      logic crx;
      repeat (3) @(posedge ref_clk);
      for (int i = 0; i < 4; i++) begin
         cd[i] = !cfg_s[i] ? cfg_s[4+i] : (sel_s[i] ? spi2_drive[i] : timer_output_enable[i]);
         co[i] = !cfg_s[i] ? portc_gpio_out[i] : (sel_s[i] ? spi2_out[i] : timer_out[i]);
         cp[i] = cd[i] ? co[i] : ext_c[i];
         ti[i] = cfg_s[i] & !sel_s[i] & cp[i];
         si[i] = cfg_s[i] & sel_s[i] & cp[i];
      end
      dd[0] = !cfg_s[8] ? cfg_s[10] : 1'b1;
      dout[0] = !cfg_s[8] ? portd_gpio_out[0]
                          : (sel_s[4] ? second_can_transmit : mem_chip_select_2);
      dd[1] = !cfg_s[9] ? cfg_s[11] : !sel_s[5];
      dout[1] = !cfg_s[9] ? portd_gpio_out[1] : mem_chip_select_3;
      for (int j = 0; j < 2; j++) dp[j] = dd[j] ? dout[j] : ext_d[j];
      crx = (cfg_s[9] & sel_s[5]) ? dp[1] : 1'b1;
      for (int i = 0; i < 4; i++) begin
         compare(pc_drv[i].oe_n, !cd[i]);
         if (cd[i]) compare(pc_drv[i].out, co[i]);
      end
      for (int j = 0; j < 2; j++) begin
         compare(pd_drv[j].oe_n, !dd[j]);
         if (dd[j]) compare(pd_drv[j].out, dout[j]);
      end
      compare(portc_gpio_in, cp);
      compare(timer_in, ti);
      compare(decoder_in, ti);
      compare(spi2_in, si);
      compare(portd_gpio_in, dp);
      compare(second_can_receive, crx);
      bus_rd(8'h44, r);
      compare(r, {26'h0, dd, cd});
      bus_rd(8'h2c, r);
      compare(r, {26'h0, sel_s});
   endtask : check_all

   task automatic t_reset;
      logic [31:0] r;
      reset_n <= 1'b0;
      repeat (20) @(posedge ref_clk);
      reset_n <= 1'b1;
      @(posedge ref_clk);
      sel_s = 6'h00;
      cfg_s = 12'h00f;
      bus_rd(8'h40, r);
      compare(r, 32'h0000000f);
      check_all();
   endtask : t_reset

   task automatic t_sel_bits;
      logic [31:0] r;
      bus_wr(8'h2c, 32'h0000ffff, 4'h3);
      bus_rd(8'h2c, r);
      compare(r, 32'h0000003f);
      bus_wr(8'h2c, 32'h0000ff00, 4'h2);
      bus_rd(8'h2c, r);
      compare(r, 32'h0000003f);
      bus_wr(8'h00, 32'h0000ffff, 4'h3);
      bus_rd(8'h00, r);
      compare(r, 32'h00000000);
      bus_wr(8'h44, 32'h0000ffff, 4'h3);
      wr_sel(6'h15);
      check_all();
   endtask : t_sel_bits

   task automatic t_portc_timer;
      wr_sel(6'h00);
      timer_output_enable <= 4'b0101;
      timer_out <= 4'b0011;
      ext_c <= 4'b1010;
      check_all();
      timer_output_enable <= 4'b1010;
      timer_out <= 4'b1100;
      ext_c <= 4'b0101;
      spi2_drive <= 4'hf;
      check_all();
   endtask : t_portc_timer

   task automatic t_portc_spi;
      spi2_drive <= 4'b0110;
      spi2_out <= 4'b1011;
      ext_c <= 4'b1001;
      timer_output_enable <= 4'hf;
      for (int i = 0; i < 4; i++) begin
         wr_sel(6'h01 << i);
         check_all();
      end
      wr_sel(6'h0f);
      spi2_drive <= 4'b1001;
      check_all();
   endtask : t_portc_spi

   task automatic t_portc_gpio;
      wr_sel(6'h0a);
      wr_cfg(12'h04a);
      portc_gpio_out <= 4'b0101;
      check_all();
      wr_cfg(12'h0f0);
      check_all();
   endtask : t_portc_gpio

   task automatic t_portd;
      wr_cfg(12'h80f);
      portd_gpio_out <= 2'b11;
      ext_d <= 2'b01;
      check_all();
      wr_cfg(12'h30f);
      for (int s = 0; s < 4; s++) begin
         wr_sel({s[1:0], 4'h0});
         mem_chip_select_2 <= s[0];
         mem_chip_select_3 <= !s[0];
         second_can_transmit <= s[1];
         ext_d <= {s[0], s[1]};
         check_all();
      end
      wr_cfg(12'h10f);
      check_all();
   endtask : t_portd

   initial begin
      err_count = 0;
      n_checks = 0;
      cyc_count = 0;
      reset_n <= 1'b0;
      {avs_read, avs_write, avs_address, avs_writedata, avs_byteenable} <= '0;
      {portc_gpio_out, portd_gpio_out, timer_out, timer_output_enable} <= '0;
      {spi2_out, spi2_drive, ext_c, ext_d} <= '0;
      {mem_chip_select_2, mem_chip_select_3, second_can_transmit} <= '0;
      t_reset();
      t_sel_bits();
      t_portc_timer();
      t_portc_spi();
      t_portc_gpio();
      t_portd();
      t_reset();
      give_verdict();
   end
endmodule : afps_pin_select_bench

`default_nettype wire
